// >>> design/tbf_framer.sv
// Transmit backplane framing: sync, link sampling, channel blocking.
// How it works
// R1: Sync multiframe select 0 marks frames on sync pin, 1 marks multiframes.
// R2: Double-wide enable stretches the frame-mode sync pulse to two bits.
// R3: D4 samples link data at even-frame F bits, inserted when enabled.
// R4: ESF without zero-byte interchange samples link at odd-frame F bits.
// R5: ESF with interchange samples link only in frames 1,5,9,13,17,21.
// R6: System side times link data only from the link clock.
// R7: Sync direction 0 makes sync pin an input aligning transmit timing.
// R8: 2.048 MHz mode ignores serial data in channels 1,5,...,29.
// R9: 2.048 MHz mode forces channel block high in ignored channels.
// R10: 2.048 MHz F bit taken from channel 1 MSB; overwritten unless pass-through.
// R11: Per-channel block; signaling insert ignores signaling in blocked channels.
// R12: Interleaved bus at 4.096 MHz for two, 8.192 MHz for four framers.
// R13: Receive interleaved frame mode requires receive sync as input.
// R14: A frame is 193 bits: F bit then 24 channels, MSB first.
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tbf_framer
   import tbf_pkg::*;
(
   // System clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Software port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Backplane serial inputs, sampled on the system clock
   input wire logic tx_serial_data_in,
   input wire logic tx_signaling_in,
   // Two-way transmit sync pin
   input wire logic tx_sync_pulse_in,
   output logic tx_sync_pulse_out,
   output logic tx_sync_pulse_oe,
   // Receive sync direction
   output logic rx_sync_pulse_input_mode,
   // Transmit line side
   input wire logic line_clock,
   output logic tx_line_data_out,
   output logic tx_frame_sync_out,
   output logic tx_channel_block_out,
   output logic tx_link_clock_out,
   input wire logic tx_link_data_in,
   output logic [1:0] bus_mode_out
);
   // ==========================================================
   // Registers
   logic [15:0] ctrl_q;
   logic [31:0] block_q;
   logic [31:0] rdata_q;
   logic [23:0] link_capt_q;
   wire sync_mf = ctrl_q[TBF_CTRL_SYNC_MF];
   wire dwide = ctrl_q[TBF_CTRL_DWIDE];
   wire zbtsi = ctrl_q[TBF_CTRL_ZBTSI];
   wire sync_out_dir = ctrl_q[TBF_CTRL_SYNC_DIR];
   wire link_ins = ctrl_q[TBF_CTRL_LINK_INS];
   wire esf = ctrl_q[TBF_CTRL_ESF];
   wire es2048 = ctrl_q[TBF_CTRL_ES2048];
   wire fpass = ctrl_q[TBF_CTRL_FPASS];
   wire sig_ins = ctrl_q[TBF_CTRL_SIG_INS];
   // ==========================================================
   // Software port
   wire wr_ctrl = reg_wr && (reg_addr == TBF_ADDR_CTRL);
   wire wr_block = reg_wr && (reg_addr == TBF_ADDR_BLOCK);
   logic [31:0] status_word;
   logic [31:0] rd_mux;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ctrl_q <= TBF_CTRL_RESET;
         block_q <= TBF_BLOCK_RESET;
         rdata_q <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= reg_wdata[15:0];
         end
         if (wr_block) begin
            block_q <= reg_wdata;
         end
         rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end
   assign reg_rdata = rdata_q;
   assign rx_sync_pulse_input_mode = ctrl_q[TBF_CTRL_RX_SYNC_IN]; // R13
   assign bus_mode_out = ctrl_q[TBF_CTRL_BUS_MODE +: 2]; // R12
   // ==========================================================
   // Sync pin input: two flops, then an edge detect
   logic sync_in_s;
   logic sync_in_prev_q;
   tbf_sync2 u_sync_in (
      .clock(clock),
      .nrst(nrst),
      .async_in(tx_sync_pulse_in),
      .sync_out(sync_in_s)
   );
   wire sync_rise = sync_in_s && !sync_in_prev_q && !sync_out_dir; // R7
   // ==========================================================
   // Bit and frame counters on the system clock
   logic [7:0] bit_q;
   logic [4:0] frame_q;
   wire [7:0] bits_per_frame = es2048 ? 8'd255 : TBF_FRAME_BITS - 8'd1;
   wire [4:0] mf_len = esf ? TBF_MF_FRAMES_ESF : TBF_MF_FRAMES_D4;
   wire last_bit = (bit_q == bits_per_frame);
   always_ff @(posedge clock) begin
      if (!nrst) begin
         bit_q <= 8'h00;
         frame_q <= 5'h00;
         sync_in_prev_q <= 1'b0;
      end else begin
         sync_in_prev_q <= sync_in_s;
         if (sync_rise) begin
            bit_q <= 8'h01; // R7
            // A sync edge on a boundary that the counter already wrapped must not count twice.
            if (sync_mf) begin
               frame_q <= 5'h00;
            end else if (bit_q == 8'h00) begin
               frame_q <= frame_q;
            end else if (frame_q == mf_len - 5'd1) begin
               frame_q <= 5'h00;
            end else begin
               frame_q <= frame_q + 5'd1;
            end
         end else if (last_bit) begin
            bit_q <= 8'h00; // R14
            frame_q <= (frame_q == mf_len - 5'd1) ? 5'h00 : frame_q + 5'd1;
         end else begin
            bit_q <= bit_q + 8'd1;
         end
      end
   end
   // ==========================================================
   // Channel position: 193-bit frame or 32-slot backplane
   wire [7:0] chan_bit_idx = es2048 ? bit_q : bit_q - 8'd1;
   wire [4:0] chan = chan_bit_idx[7:3];
   wire fbit_pos = es2048 ? (bit_q == 8'h00) : (bit_q == 8'h00); // R14
   wire ignored_chan = es2048 && (chan[1:0] == 2'b00); // R8
   wire blocked = block_q[chan]; // R11
   wire [4:0] frame_num = frame_q + 5'd1;
   // ==========================================================
   // Frame sync output and sync pin output
   wire first_frame = (frame_q == 5'h00);
   wire frame_pulse = (bit_q == 8'h00) || (dwide && bit_q == 8'h01); // R2
   wire sync_mark = sync_mf ? (frame_pulse && first_frame) : frame_pulse; // R1
   logic sync_out_q;
   logic fsync_q;
   logic block_out_q;
   logic serial_q;
   logic sig_used_q;
   logic fbit_store_q;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sync_out_q <= 1'b0;
         fsync_q <= 1'b0;
         block_out_q <= 1'b0;
         serial_q <= 1'b0;
         sig_used_q <= 1'b0;
         fbit_store_q <= 1'b0;
      end else begin
         sync_out_q <= sync_mark; // R1
         fsync_q <= frame_pulse;
         block_out_q <= blocked || ignored_chan; // R9
         sig_used_q <= (sig_ins && blocked) ? 1'b0 : tx_signaling_in; // R11
         if (es2048 && bit_q == 8'h00) begin
            fbit_store_q <= tx_serial_data_in; // R10
         end
         serial_q <= ignored_chan ? serial_q : tx_serial_data_in; // R8
      end
   end
   assign tx_sync_pulse_out = sync_out_q;
   assign tx_sync_pulse_oe = sync_out_dir; // R7
   assign tx_frame_sync_out = fsync_q;
   assign tx_channel_block_out = block_out_q;
   // ==========================================================
   // Link sampling selection per framing mode
   wire even_frame = !frame_num[0];
   wire z_frame = (frame_num == 5'd1) || (frame_num == 5'd5) || (frame_num == 5'd9) ||
                  (frame_num == 5'd13) || (frame_num == 5'd17) || (frame_num == 5'd21);
   wire link_slot = !esf ? even_frame : // R3
                    (zbtsi ? z_frame : !even_frame); // R4 R5
   wire link_req = fbit_pos && link_slot;
   // ==========================================================
   // Link domain: request toggles across, acknowledge toggles back with the sampled bit
   logic req_tog_q;
   logic lk_req_s;
   logic lk_req_prev_q;
   logic lk_bit_q;
   logic lk_ack_q;
   logic ack_s;
   logic ack_prev_q;
   logic line_q;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         req_tog_q <= 1'b0;
         ack_prev_q <= 1'b0;
         link_capt_q <= 24'h000000;
         line_q <= 1'b0;
      end else begin
         if (link_req) begin
            req_tog_q <= !req_tog_q;
         end
         ack_prev_q <= ack_s;
         if (ack_s != ack_prev_q) begin
            link_capt_q <= {link_capt_q[22:0], lk_bit_q};
         end
         if (fbit_pos && link_slot && link_ins) begin
            line_q <= link_capt_q[0]; // R3 R4 R5
         end else if (fbit_pos && es2048) begin
            line_q <= fpass ? tx_serial_data_in : 1'b0; // R10
         end else begin
            line_q <= ignored_chan ? 1'b1 : serial_q;
         end
      end
   end
   assign tx_line_data_out = line_q;
   tbf_sync2 u_req_sync (
      .clock(line_clock),
      .nrst(nrst),
      .async_in(req_tog_q),
      .sync_out(lk_req_s)
   );
   tbf_sync2 u_ack_sync (
      .clock(clock),
      .nrst(nrst),
      .async_in(lk_ack_q),
      .sync_out(ack_s)
   );
   // Link data is timed only from the link clock, never from frame sync.
   logic lk_clk_q;
   always_ff @(posedge line_clock) begin
      if (!nrst) begin
         lk_req_prev_q <= 1'b0;
         lk_bit_q <= 1'b0;
         lk_ack_q <= 1'b0;
         lk_clk_q <= 1'b0;
      end else begin
         lk_req_prev_q <= lk_req_s;
         lk_clk_q <= (lk_req_s != lk_req_prev_q); // R6
         if (lk_req_s != lk_req_prev_q) begin
            lk_bit_q <= tx_link_data_in;
            lk_ack_q <= !lk_ack_q;
         end
      end
   end
   assign tx_link_clock_out = lk_clk_q;
   // ==========================================================
   // Read mux and status
   assign status_word = {16'h0000, 3'b000, frame_q, bit_q};
   assign rd_mux = (reg_addr == TBF_ADDR_CTRL) ? {16'h0000, ctrl_q} :
                   (reg_addr == TBF_ADDR_BLOCK) ? block_q :
                   (reg_addr == TBF_ADDR_STATUS) ?
                   {status_word[31:17], sig_used_q, status_word[15:1], fbit_store_q} : // R11
                   (reg_addr == TBF_ADDR_LINKDATA) ? {8'h00, link_capt_q} :
                   32'h0000_0000;
endmodule // tbf_framer
`default_nettype wire

// >>> design/tbf_pkg.sv
// Constants and types shared by the transmit backplane framing block.
package tbf_pkg;
   // ==========================================================
   // Register map of the plain software port
   localparam logic [3:0] TBF_ADDR_CTRL = 4'h0;
   localparam logic [3:0] TBF_ADDR_BLOCK = 4'h1;
   localparam logic [3:0] TBF_ADDR_STATUS = 4'h2;
   localparam logic [3:0] TBF_ADDR_LINKDATA = 4'h3;
   // ==========================================================
   // Control register field positions
   localparam int TBF_CTRL_SYNC_MF = 0;
   localparam int TBF_CTRL_DWIDE = 1;
   localparam int TBF_CTRL_ZBTSI = 2;
   localparam int TBF_CTRL_SYNC_DIR = 3;
   localparam int TBF_CTRL_LINK_INS = 4;
   localparam int TBF_CTRL_ESF = 5;
   localparam int TBF_CTRL_ES2048 = 6;
   localparam int TBF_CTRL_FPASS = 7;
   localparam int TBF_CTRL_SIG_INS = 8;
   localparam int TBF_CTRL_RX_SYNC_IN = 9;
   localparam int TBF_CTRL_BUS_MODE = 10;
   localparam logic [15:0] TBF_CTRL_RESET = 16'h0008;
   localparam logic [31:0] TBF_BLOCK_RESET = 32'h0000_0000;
   // ==========================================================
   // Frame structure
   localparam logic [7:0] TBF_FRAME_BITS = 8'd193;
   localparam logic [4:0] TBF_MF_FRAMES_D4 = 5'd12;
   localparam logic [4:0] TBF_MF_FRAMES_ESF = 5'd24;
   localparam logic [4:0] TBF_CHANNELS_2048 = 5'd31;
   // ==========================================================
   // Bus modes of the interleaved backplane
   typedef enum logic [1:0] {
      TBF_BUS_SINGLE = 2'h0,
      TBF_BUS_4096 = 2'h1,
      TBF_BUS_8192 = 2'h3
   } tbf_bus_type;
endpackage

// >>> design/tbf_sync2.sv
// Two-flop level synchroniser.
`timescale 1ns/1ps
`default_nettype none
module tbf_sync2 (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Level
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q;
   logic sync_q;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   assign sync_out = sync_q;
endmodule // tbf_sync2
`default_nettype wire

// >>> test/tb_t1_tx_backplane_framing.sv
// Self-checking testbench of the transmit backplane framer.
`timescale 1ns/1ps
`default_nettype none
module tb_t1_tx_backplane_framing;
   import tbf_pkg::*;
   // ====================
   // Signals and instances
   logic clock = 1'b0;
   logic line_clock = 1'b0;
   logic nrst = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic ser, sig, link, sync_in, sp_out, sp_oe, rx_mode, line_data, fso, blk, lclk;
   logic [1:0] bus_mode;
   int mismatches = 0;
   int n_compared = 0;
   int n_lclk = 0;
   initial forever #50 clock = ~clock;
   initial begin
      #7;
      forever #24 line_clock = ~line_clock;
   end
   tbf_framer u_tbf_framer (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_serial_data_in(ser), .tx_signaling_in(sig), .tx_sync_pulse_in(sync_in),
      .tx_sync_pulse_out(sp_out), .tx_sync_pulse_oe(sp_oe),
      .rx_sync_pulse_input_mode(rx_mode), .line_clock(line_clock),
      .tx_line_data_out(line_data), .tx_frame_sync_out(fso), .tx_channel_block_out(blk),
      .tx_link_clock_out(lclk), .tx_link_data_in(link), .bus_mode_out(bus_mode));
   tbf_backplane u_tbf_backplane (.clock(clock), .line_clock(line_clock),
      .tx_link_clock_out(lclk), .tx_serial_data_in(ser), .tx_signaling_in(sig),
      .tx_link_data_in(link), .tx_sync_pulse_in(sync_in));
   always @(posedge line_clock) if (lclk === 1'b1) n_lclk++;
   // ====================
   // Tasks
   task complete_run;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task peek(input logic [3:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] d;
      peek(a, d);
      chk(d, e);
   endtask
   task phase(input logic f, input logic v, output int n);
      n = 0;
      while ((f ? fso : sp_out) === v && n < 3000) begin
         @(negedge clock);
         n++;
      end
   endtask
   task t_regs;
      rd(TBF_ADDR_CTRL, {16'h0, TBF_CTRL_RESET});
      rd(TBF_ADDR_BLOCK, TBF_BLOCK_RESET);
      chk({31'h0, sp_oe}, 32'h1);
      wr(TBF_ADDR_CTRL, 32'h0000_0608);
      #1 chk({29'h0, rx_mode, bus_mode}, 32'h5);
      wr(TBF_ADDR_CTRL, 32'h0000_0c08);
      #1 chk({30'h0, bus_mode}, 32'h3);
      wr(TBF_ADDR_BLOCK, 32'h8000_0002);
      rd(TBF_ADDR_BLOCK, 32'h8000_0002);
      rd(4'hf, 32'h0);
      $display("t_regs done");
   endtask
   task t_sync(input logic [31:0] c, input logic f, input int w, input int p);
      int h, n;
      wr(TBF_ADDR_CTRL, c);
      repeat (2) begin
         phase(f, 1'b1, n);
         phase(f, 1'b0, n);
      end
      phase(f, 1'b1, h);
      phase(f, 1'b0, n);
      chk(h, w);
      chk(h + n, p);
      $display("t_sync %h done", c);
   endtask
   task t_block(input logic [31:0] c, input logic [31:0] b, input int len, input int exp);
      int n;
      wr(TBF_ADDR_CTRL, c);
      wr(TBF_ADDR_BLOCK, b);
      repeat (260) @(posedge clock);
      n = 0;
      repeat (len) begin
         @(negedge clock);
         n += blk;
      end
      chk(n, exp);
      $display("t_block %h %h done", c, b);
   endtask
   task t_sig;
      logic [31:0] d;
      wr(TBF_ADDR_BLOCK, 32'hffff_ffff);
      wr(TBF_ADDR_CTRL, 32'h0000_0148);
      peek(TBF_ADDR_STATUS, d);
      chk({31'h0, d[16]}, 32'h0);
      wr(TBF_ADDR_CTRL, 32'h0000_0048);
      peek(TBF_ADDR_STATUS, d);
      chk({31'h0, d[16]}, 32'h1);
      $display("t_sig done");
   endtask
   task t_fbit(input logic [31:0] c);
      wr(TBF_ADDR_CTRL, c);
      repeat (2) @(posedge clock);
      @(posedge fso);
      @(negedge clock);
      chk({31'h0, line_data}, {31'h0, c[TBF_CTRL_FPASS] & ~ser});
      $display("t_fbit %h done", c);
   endtask
   task t_link(input logic [31:0] c, input int len, input int exp);
      int n0;
      logic [31:0] d;
      wr(TBF_ADDR_CTRL, c);
      repeat (300) @(posedge clock);
      @(posedge fso);
      repeat (96) @(posedge clock);
      n0 = n_lclk;
      repeat (len) @(posedge clock);
      chk(n_lclk - n0, exp);
      peek(TBF_ADDR_LINKDATA, d);
      chk({31'h0, d[3:0] == 4'h5 || d[3:0] == 4'ha}, 32'h1);
      $display("t_link %h done", c);
   endtask
   // ====================
   // Main sequence
   initial begin
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      t_regs();
      t_sync(32'h0000_0008, 1'b0, 1, 193);
      t_sync(32'h0000_000a, 1'b0, 2, 193);
      t_sync(32'h0000_0009, 1'b0, 1, 2316);
      t_sync(32'h0000_0000, 1'b1, 1, 250);
      t_block(32'h0000_0008, 32'h0000_0002, 193, 8);
      t_block(32'h0000_0048, 32'h0000_0000, 256, 64);
      t_block(32'h0000_0048, 32'h8000_0000, 256, 72);
      t_sig();
      t_fbit(32'h0000_0048);
      t_fbit(32'h0000_00c8);
      t_link(32'h0000_0018, 2316, 6);
      t_link(32'h0000_0038, 4632, 12);
      t_link(32'h0000_003c, 4632, 6);
      complete_run();
   end
   initial begin
      #5000000;
      mismatches++;
      complete_run();
   end
endmodule // tb_t1_tx_backplane_framing
`default_nettype wire

// >>> test/tbf_backplane.sv
// Behavioural model of the system backplane logic feeding the framer.
`timescale 1ns/1ps
`default_nettype none
module tbf_backplane (
   // Clocks
   input wire logic clock,
   input wire logic line_clock,
   input wire logic tx_link_clock_out,
   // Backplane drive
   output logic tx_serial_data_in,
   output logic tx_signaling_in,
   output logic tx_link_data_in,
   output logic tx_sync_pulse_in
);
   // ====================
   // Stimulus
   initial begin
      tx_serial_data_in = 1'b0;
      tx_signaling_in = 1'b1;
      tx_link_data_in = 1'b0;
      tx_sync_pulse_in = 1'b0;
   end
   // Signaling stays high, so a zero read back proves a blocked slot ignored it.
   // Sync pulses come every 250 clocks, off the 193-bit frame, so realignment is visible.
   int sync_cnt = 0;
   always @(posedge clock) begin
      tx_serial_data_in <= ~tx_serial_data_in;
      sync_cnt <= (sync_cnt == 249) ? 0 : sync_cnt + 1;
      tx_sync_pulse_in <= (sync_cnt == 0);
   end
   // Link bits advance only on the link clock, never on frame timing.
   always @(posedge line_clock) begin
      if (tx_link_clock_out) tx_link_data_in <= ~tx_link_data_in;
   end
endmodule // tbf_backplane
`default_nettype wire

// >>> test/tbf_framer_checker.sv
// Concurrent checks on the ports of the transmit backplane framer.
`timescale 1ns/1ps
`default_nettype none
module tbf_framer_checker
   import tbf_pkg::*;
(
   // Clocks and reset
   input wire logic clock,
   input wire logic nrst,
   input wire logic line_clock,
   // Software port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Outputs
   input wire logic tx_sync_pulse_out,
   input wire logic tx_sync_pulse_oe,
   input wire logic rx_sync_pulse_input_mode,
   input wire logic tx_link_clock_out,
   input wire logic [1:0] bus_mode_out
);
   // ====================
   // Control shadow
   // Frame checks rest for 300 cycles after a control write: a mode change may stretch one frame.
   logic dw_q;
   logic mf_q;
   logic es_q;
   logic [8:0] quiet_q;
   wire ctrl_wr = reg_wr && reg_addr == TBF_ADDR_CTRL;
   wire settled = quiet_q == 9'h12c;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         dw_q <= 1'b0;
         mf_q <= 1'b0;
         es_q <= 1'b0;
         quiet_q <= 9'h000;
      end else if (ctrl_wr) begin
         dw_q <= reg_wdata[TBF_CTRL_DWIDE];
         mf_q <= reg_wdata[TBF_CTRL_SYNC_MF];
         es_q <= reg_wdata[TBF_CTRL_ES2048];
         quiet_q <= 9'h000;
      end else if (!settled) begin
         quiet_q <= quiet_q + 9'h001;
      end
   end
   oe_follow_a: assert property (@(posedge clock) disable iff (!nrst)
      ctrl_wr |=> tx_sync_pulse_oe == $past(reg_wdata[TBF_CTRL_SYNC_DIR]))
      else $error("sync pin direction does not follow control write");
   oe_hold_a: assert property (@(posedge clock) disable iff (!nrst)
      !ctrl_wr |=> $stable(tx_sync_pulse_oe)) else $error("sync pin direction changed alone");
   rx_mode_a: assert property (@(posedge clock) disable iff (!nrst)
      ctrl_wr |=> rx_sync_pulse_input_mode == $past(reg_wdata[TBF_CTRL_RX_SYNC_IN]))
      else $error("receive sync mode does not follow control write");
   bus_mode_a: assert property (@(posedge clock) disable iff (!nrst)
      ctrl_wr |=> bus_mode_out == $past(reg_wdata[11:10])) else $error("bus mode wrong");
   rdata_idle_a: assert property (@(posedge clock) disable iff (!nrst)
      !reg_rd |=> reg_rdata == 32'h0) else $error("read data outside read cycle");
   sync_single_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(tx_sync_pulse_out) && tx_sync_pulse_oe && !dw_q && !mf_q && settled
      |=> !tx_sync_pulse_out) else $error("single sync pulse too wide");
   sync_double_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(tx_sync_pulse_out) && tx_sync_pulse_oe && dw_q && !mf_q && settled
      |=> tx_sync_pulse_out ##1 !tx_sync_pulse_out) else $error("double sync width wrong");
   frame_period_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(tx_sync_pulse_out) && tx_sync_pulse_oe && !mf_q && !es_q && settled
      |-> ##193 ($rose(tx_sync_pulse_out) || mf_q || !settled)) else $error("frame not 193");
   frame_2048_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(tx_sync_pulse_out) && tx_sync_pulse_oe && !mf_q && es_q && settled
      |-> ##256 ($rose(tx_sync_pulse_out) || !settled)) else $error("backplane frame not 256");
   mf_skip_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(tx_sync_pulse_out) && tx_sync_pulse_oe && mf_q && settled
      |-> ##193 (!tx_sync_pulse_out || !mf_q || !settled)) else $error("frame marked in mf mode");
   link_pulse_a: assert property (@(posedge line_clock) disable iff (!nrst)
      $rose(tx_link_clock_out) |=> !tx_link_clock_out) else $error("link clock pulse too long");
endmodule // tbf_framer_checker
bind tbf_framer tbf_framer_checker u_tbf_framer_checker (.clock, .nrst, .line_clock,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_sync_pulse_out,
   .tx_sync_pulse_oe, .rx_sync_pulse_input_mode, .tx_link_clock_out, .bus_mode_out);
`default_nettype wire
